// ===== verilog/fdp_port.sv
// Bus-side transfer logic of a floppy disk controller board.
// Assumes a same-clock bus master port, arbiter and register port; the
// controller chip pins and jumpers are asynchronous and are synchronised.
//
// Notes on behaviour
// - DMA mode moves disk data to and from memory as bus master.
// - Every DMA bus transfer carries one full 16-bit word.
// - Without DMA, the host moves one byte per register access.
// - End of command raises interrupt on level 1 to 6 from control.
// - DMA bus request level comes from jumpers, not from software.
// - A 256-byte FIFO sits between controller chip and bus.
// - DMA fills or drains the FIFO until word count is done, then stops.
// - Programmed byte transfers go straight to the chip, skipping FIFO.
// - Registers answer in a short I/O window set by jumpers.
// - Control holds interrupt level, DMA enable, user access, LED status.
// - The red/green lamp shows the diagnostic status bit.
// - Drive control selects density, drive size and precompensation.
// - Up to four drives are addressed and selected.
`timescale 1ns/10ps
module fdp_port
   import fdp_pkg::*;
#(
   parameter int FIFO_BYTES = 256,
   parameter int BASE_W     = 11,
   parameter int MADDR_W    = 24
)(
   // Clock, reset and freeze.
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire logic                 clk_en,
   // Register port.
   input  wire logic [15:0]          reg_addr,
   input  wire logic [REG_W-1:0]     reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic                 reg_super,
   output logic      [REG_W-1:0]     reg_rdata,
   // Jumpers.
   input  wire logic [BASE_W-1:0]    jmp_io_base,
   input  wire logic [1:0]           jmp_breq_level,
   // Bus master port.
   output logic                      mst_req,
   output logic      [3:0]           mst_req_line,
   input  wire logic                 mst_gnt,
   output logic      [MADDR_W-1:0]   mst_addr,
   output logic                      mst_we,
   output logic      [15:0]          mst_wdata,
   input  wire logic [15:0]          mst_rdata,
   input  wire logic                 mst_ack,
   // Interrupt.
   output logic                      irq,
   output logic      [5:0]           irq_line,
   // Disk controller chip.
   output logic      [1:0]           fdc_reg,
   output logic                      fdc_rd,
   output logic                      fdc_wr,
   output logic      [7:0]           fdc_dout,
   input  wire logic [7:0]           fdc_din,
   input  wire logic                 fdc_drq,
   input  wire logic                 fdc_intrq,
   // Drive and lamp outputs.
   output logic      [3:0]           drv_select,
   output logic                      drv_double_density,
   output logic                      drv_mini,
   output logic                      drv_precomp,
   output logic                      led_green,
   output logic                      led_red
);
   localparam int AW = $clog2(FIFO_BYTES);

   if (FIFO_BYTES < 4 || (1 << AW) != FIFO_BYTES)
   begin : g_bad_fifo
      $error("FIFO_BYTES must be a power of two of at least 4.");
   end
   if (MADDR_W < 17 || MADDR_W > 32 || BASE_W + WIN_SH != 16)
   begin : g_bad_width
      $error("Address widths do not fit the register and bus ports.");
   end

   // Two-flop synchronisers for the pins and jumpers.
   logic [7:0]        din_m_q, din_s_q;
   logic [1:0]        drq_m_q, drq_s_q;
   logic [BASE_W-1:0] base_m_q, base_s_q;
   logic [1:0]        breq_m_q, breq_s_q;
   logic              intrq_d1_q;

   always_ff @(posedge mclk)
   begin
      if (clk_en)
      begin
         din_m_q  <= fdc_din;
         din_s_q  <= din_m_q;
         drq_m_q  <= {fdc_intrq, fdc_drq};
         drq_s_q  <= drq_m_q;
         base_m_q <= jmp_io_base;
         base_s_q <= base_m_q;
         breq_m_q <= jmp_breq_level;
         breq_s_q <= breq_m_q;
      end
   end

   // Register decode.
   function automatic logic win_hit(input logic [15:0] a,
                                    input logic [BASE_W-1:0] b);
      win_hit = (a[15:WIN_SH] == b);
   endfunction

   logic [7:0]          ctrl_q;
   logic [4:0]          drv_q;
   logic                acc_ok;
   logic                wr_ok;
   logic                rd_ok;
   logic [3:0]          widx;
   logic                pio_sel;
   logic                dma_on;
   logic                dir_in;

   assign widx    = reg_addr[4:1];
   assign acc_ok  = win_hit(reg_addr, base_s_q)
                    && (reg_super || ctrl_q[CTRL_USER]);
   assign wr_ok   = reg_wr && acc_ok;
   assign rd_ok   = reg_rd && acc_ok;
   assign pio_sel = (widx[3:2] == OFS_PIO_HI);
   assign dma_on  = ctrl_q[CTRL_DMA];
   assign dir_in  = ctrl_q[CTRL_DIR];

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         ctrl_q <= CTRL_RST;
         drv_q  <= DRV_RST;
      end
      else if (clk_en && wr_ok)
      begin
         if (widx == OFS_CTRL)
            ctrl_q <= reg_wdata[7:0];
         if (widx == OFS_DRV)
            drv_q <= reg_wdata[4:0];
      end
   end

   // FIFO between chip and bus.
   logic [7:0]  fifo_mem [FIFO_BYTES];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] lvl_q;
   logic        d_push, d_pop, m_push, m_pop;
   logic [7:0]  d_byte;

   always_ff @(posedge mclk)
   begin
      if (clk_en)
      begin
         if (d_push)
            fifo_mem[wp_q] <= d_byte;
         else if (m_push)
         begin
            fifo_mem[wp_q]                  <= mst_rdata[15:8];
            fifo_mem[AW'(wp_q + AW'(1))]    <= mst_rdata[7:0];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset || (clk_en && !dma_on))
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         lvl_q <= '0;
      end
      else if (clk_en)
      begin
         wp_q  <= wp_q + (d_push ? AW'(1) : m_push ? AW'(2) : AW'(0));
         rp_q  <= rp_q + (d_pop ? AW'(1) : m_pop ? AW'(2) : AW'(0));
         lvl_q <= lvl_q + (d_push ? (AW+1)'(1) : m_push ? (AW+1)'(2) : '0)
                        - (d_pop ? (AW+1)'(1) : m_pop ? (AW+1)'(2) : '0);
      end
   end

   // DMA engine on the memory side.
   fdp_dma_type         dma_st_q;
   logic [MADDR_W-1:0]  maddr_q;
   logic [15:0]         cnt_q;
   logic                word_avail;
   logic                word_room;
   logic                dma_done;

   assign word_avail = (lvl_q >= (AW+1)'(2));
   assign word_room  = (lvl_q <= (AW+1)'(FIFO_BYTES - 2));
   assign m_pop      = (dma_st_q == DMA_REQ) && mst_gnt && dir_in;
   assign m_push     = (dma_st_q == DMA_XFER) && mst_ack && !dir_in;
   assign dma_done   = (dma_st_q == DMA_XFER) && mst_ack
                       && (cnt_q == 16'h0001);

   always_ff @(posedge mclk)
   begin
      if (reset)
         dma_st_q <= DMA_IDLE;
      else if (clk_en)
      begin
         case (dma_st_q)
            DMA_IDLE:
               if (dma_on && cnt_q != 16'h0000
                   && (dir_in ? word_avail : word_room))
                  dma_st_q <= DMA_REQ;
            DMA_REQ:
               if (mst_gnt)
                  dma_st_q <= DMA_XFER;
            DMA_XFER:
               if (mst_ack)
                  dma_st_q <= DMA_IDLE;
            default:
               dma_st_q <= DMA_IDLE;
         endcase
      end
   end

   // Disk-to-memory is a bus write; words pair high byte first.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         mst_we    <= 1'b0;
         mst_wdata <= 16'h0000;
      end
      else if (clk_en && m_pop)
      begin
         mst_we    <= 1'b1;
         mst_wdata <= {fifo_mem[rp_q], fifo_mem[AW'(rp_q + AW'(1))]};
      end
      else if (clk_en && dma_st_q == DMA_REQ && mst_gnt)
         mst_we <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         maddr_q <= '0;
         cnt_q   <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (wr_ok && widx == OFS_ADRL)
            maddr_q[15:0] <= {reg_wdata[15:1], 1'b0};
         else if (wr_ok && widx == OFS_ADRH)
            maddr_q[MADDR_W-1:16] <= reg_wdata[MADDR_W-17:0];
         else if (dma_st_q == DMA_XFER && mst_ack)
            maddr_q <= maddr_q + MADDR_W'(2);
         if (wr_ok && widx == OFS_CNT)
            cnt_q <= reg_wdata;
         else if (dma_st_q == DMA_XFER && mst_ack)
            cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign mst_req      = (dma_st_q != DMA_IDLE);
   assign mst_addr     = maddr_q;
   assign mst_req_line = mst_req ? (4'h1 << breq_s_q) : 4'h0;

   // Chip side: DMA byte mover and programmed byte access share one strobe.
   fdp_fs_type fs_st_q;
   logic [3:0] fs_cnt_q;
   logic       fs_read_q;
   logic       fs_dma_q;
   logic [7:0] pio_buf_q;
   logic       pio_go;

   assign pio_go = (reg_wr || reg_rd) && acc_ok && pio_sel && !dma_on
                   && (fs_st_q == FS_IDLE);
   assign d_push = (fs_st_q == FS_WAIT) && fs_cnt_q == 4'h0
                   && fs_read_q && fs_dma_q;
   assign d_byte = din_s_q;
   assign d_pop  = (fs_st_q == FS_IDLE) && dma_on && drq_s_q[0]
                   && !dir_in && lvl_q != '0;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         fs_st_q   <= FS_IDLE;
         fs_cnt_q  <= 4'h0;
         fs_read_q <= 1'b0;
         fs_dma_q  <= 1'b0;
         fdc_rd    <= 1'b0;
         fdc_wr    <= 1'b0;
         fdc_reg   <= FDC_DATA_REG;
         fdc_dout  <= 8'h00;
         pio_buf_q <= 8'h00;
      end
      else if (clk_en)
      begin
         case (fs_st_q)
            FS_IDLE:
               if (pio_go)
               begin
                  fs_st_q   <= FS_WAIT;
                  fs_cnt_q  <= 4'(FDC_STB_CYC + 1);
                  fs_read_q <= reg_rd;
                  fs_dma_q  <= 1'b0;
                  fdc_reg   <= widx[1:0];
                  fdc_rd    <= reg_rd;
                  fdc_wr    <= reg_wr;
                  fdc_dout  <= reg_wdata[7:0];
               end
               else if (dma_on && drq_s_q[0]
                        && (dir_in ? lvl_q != (AW+1)'(FIFO_BYTES)
                                   : lvl_q != '0))
               begin
                  fs_st_q   <= FS_WAIT;
                  fs_cnt_q  <= 4'(FDC_STB_CYC + 1);
                  fs_read_q <= dir_in;
                  fs_dma_q  <= 1'b1;
                  fdc_reg   <= FDC_DATA_REG;
                  fdc_rd    <= dir_in;
                  fdc_wr    <= !dir_in;
                  fdc_dout  <= fifo_mem[rp_q];
               end
            FS_WAIT:
               if (fs_cnt_q == 4'h0)
               begin
                  fs_st_q <= FS_IDLE;
                  fdc_rd  <= 1'b0;
                  fdc_wr  <= 1'b0;
                  if (fs_read_q && !fs_dma_q)
                     pio_buf_q <= din_s_q;
               end
               else
                  fs_cnt_q <= fs_cnt_q - 4'h1;
            default:
               fs_st_q <= FS_IDLE;
         endcase
      end
   end

   // Interrupt status, enable and clear; a new event beats a clear.
   logic [IRQ_W-1:0] istat_q, ien_q, ievt;

   assign ievt[IRQ_CMD] = drq_s_q[1] && !intrq_d1_q;
   assign ievt[IRQ_DMA] = dma_done;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         istat_q    <= '0;
         ien_q      <= '0;
         intrq_d1_q <= 1'b0;
      end
      else if (clk_en)
      begin
         intrq_d1_q <= drq_s_q[1];
         istat_q    <= (istat_q & ~((wr_ok && widx == OFS_ICLR)
                                    ? reg_wdata[IRQ_W-1:0] : '0)) | ievt;
         if (wr_ok && widx == OFS_IEN)
            ien_q <= reg_wdata[IRQ_W-1:0];
      end
   end

   logic [2:0] lev;
   assign lev      = ctrl_q[CTRL_LEV +: 3];
   assign irq      = |(istat_q & ien_q);
   assign irq_line = (irq && lev >= LEV_MIN && lev <= LEV_MAX)
                     ? 6'(6'h01 << (lev - LEV_MIN)) : 6'h00;

   // Read data, one cycle after the strobe; unmapped words read zero.
   always_ff @(posedge mclk)
   begin
      if (reset)
         reg_rdata <= '0;
      else if (clk_en)
      begin
         reg_rdata <= '0;
         if (rd_ok)
         begin
            if (pio_sel)
               reg_rdata <= {8'h00, pio_buf_q};
            else
            begin
               case (widx)
                  OFS_CTRL:  reg_rdata <= {8'h00, ctrl_q};
                  OFS_DRV:   reg_rdata <= {11'h000, drv_q};
                  OFS_ADRL:  reg_rdata <= maddr_q[15:0];
                  OFS_ADRH:  reg_rdata <= 16'(maddr_q[MADDR_W-1:16]);
                  OFS_CNT:   reg_rdata <= cnt_q;
                  OFS_STAT:  reg_rdata <= 16'({lvl_q, 2'b00,
                                      fs_st_q != FS_IDLE,
                                      dma_st_q != DMA_IDLE}) ;
                  OFS_ISTAT: reg_rdata <= 16'(istat_q);
                  OFS_IEN:   reg_rdata <= 16'(ien_q);
                  default:   reg_rdata <= '0;
               endcase
            end
         end
      end
   end

   assign drv_select         = 4'h1 << drv_q[DRV_SEL +: 2];
   assign drv_double_density = drv_q[DRV_DDEN];
   assign drv_mini           = drv_q[DRV_MINI];
   assign drv_precomp        = drv_q[DRV_PCMP];
   assign led_green          = ctrl_q[CTRL_LED];
   assign led_red            = !ctrl_q[CTRL_LED];

   chk_req_room: assert property (@(posedge mclk) disable iff (reset)
      $rose(mst_req) |-> $past(dir_in) ? $past(lvl_q) >= 2
                                       : $past(lvl_q) <= FIFO_BYTES - 2)
      else $error("Bus requested without word or room in FIFO.");
   chk_word_step: assert property (@(posedge mclk) disable iff (reset)
      clk_en && dma_st_q == DMA_XFER && mst_ack && !(wr_ok && widx[3:1] == 3'h1)
      |=> mst_addr == MADDR_W'($past(mst_addr) + 2))
      else $error("DMA address did not advance by one word.");
   chk_count_stop: assert property (@(posedge mclk) disable iff (reset)
      clk_en && dma_done && !(wr_ok && widx == OFS_CNT)
      |=> cnt_q == 0 ##1 !mst_req)
      else $error("DMA did not stop at end of word count.");
   chk_irq_level: assert property (@(posedge mclk) disable iff (reset)
      $onehot0(irq_line) && ((irq_line != 0) == (irq && lev inside {[1:6]})))
      else $error("Interrupt line does not match level field.");
   chk_pio_bypass: assert property (@(posedge mclk) disable iff (reset)
      clk_en && pio_go && reg_wr |=> fdc_wr && lvl_q == 0)
      else $error("Programmed write did not go straight to chip.");
   chk_user_block: assert property (@(posedge mclk) disable iff (reset)
      reg_wr && !reg_super && !ctrl_q[CTRL_USER] |=> $stable(ctrl_q))
      else $error("User write changed control without permission.");
   chk_window_miss: assert property (@(posedge mclk) disable iff (reset)
      clk_en && reg_rd && reg_addr[15:WIN_SH] != base_s_q |=> reg_rdata == 0)
      else $error("Read outside window returned data.");
   chk_fifo_bound: assert property (@(posedge mclk) disable iff (reset)
      lvl_q <= FIFO_BYTES)
      else $error("FIFO level beyond its size.");
   chk_breq_fixed: assert property (@(posedge mclk) disable iff (reset)
      mst_req |-> mst_req_line == 4'(4'h1 << jmp_breq_level))
      else $error("Bus request line not the jumper level.");
   chk_lamp_write: assert property (@(posedge mclk) disable iff (reset)
      clk_en && wr_ok && widx == OFS_CTRL
      |=> led_green == $past(reg_wdata[CTRL_LED]) && led_red != led_green)
      else $error("Lamp does not follow status bit.");
endmodule // fdp_port

// ===== verilog/fdp_pkg.sv
// Constants, register map and state types of the floppy DMA bus port.
// Assumes one 25 MHz clock domain and a 16-bit register port.
package fdp_pkg;
   localparam int          REG_W        = 16;
   localparam int          CLK_NS       = 40;
   // Word index of each register inside the short I/O window.
   localparam logic [3:0]  OFS_CTRL     = 4'h0;
   localparam logic [3:0]  OFS_DRV      = 4'h1;
   localparam logic [3:0]  OFS_ADRL     = 4'h2;
   localparam logic [3:0]  OFS_ADRH     = 4'h3;
   localparam logic [3:0]  OFS_CNT      = 4'h4;
   localparam logic [3:0]  OFS_STAT     = 4'h5;
   localparam logic [3:0]  OFS_ISTAT    = 4'h6;
   localparam logic [3:0]  OFS_ICLR     = 4'h7;
   localparam logic [3:0]  OFS_IEN      = 4'h8;
   localparam logic [1:0]  OFS_PIO_HI   = 2'h3;
   // The window spans 16 words, that is 32 bytes.
   localparam int          WIN_SH       = 5;
   // Control register fields.
   localparam int          CTRL_LEV     = 0;
   localparam int          CTRL_DMA     = 3;
   localparam int          CTRL_DIR     = 4;
   localparam int          CTRL_USER    = 6;
   localparam int          CTRL_LED     = 7;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [2:0]  LEV_MIN      = 3'h1;
   localparam logic [2:0]  LEV_MAX      = 3'h6;
   // Drive control fields.
   localparam int          DRV_SEL      = 0;
   localparam int          DRV_DDEN     = 2;
   localparam int          DRV_MINI     = 3;
   localparam int          DRV_PCMP     = 4;
   localparam logic [4:0]  DRV_RST      = 5'h00;
   // Status fields.
   localparam int          STAT_BUSY    = 0;
   localparam int          STAT_PIO     = 1;
   localparam int          STAT_LVL     = 4;
   // Interrupt status bits.
   localparam int          IRQ_W        = 2;
   localparam int          IRQ_CMD      = 0;
   localparam int          IRQ_DMA      = 1;
   // Disk controller chip register that carries data bytes.
   localparam logic [1:0]  FDC_DATA_REG = 2'h3;
   // Strobe time on the controller chip, measured from strobe start.
   localparam int          FDC_STB_NS   = 200;
   localparam int          FDC_STB_CYC  = (FDC_STB_NS + CLK_NS - 1) / CLK_NS;
   typedef enum {DMA_IDLE, DMA_REQ, DMA_XFER} fdp_dma_type;
   typedef enum {FS_IDLE, FS_WAIT}            fdp_fs_type;
endpackage

// ===== dv/fdp_far_model.sv
// Far-side model: bus arbiter with a small word memory, and the disk chip.
// Assumes the port's clock; grant and acknowledge are same-clock levels.
`timescale 1ns/10ps
module fdp_far_model
(
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        reset,
   // Bench controls.
   input  wire logic [3:0]  ack_lat,
   input  wire logic        give_go,
   input  wire logic [7:0]  give_n,
   input  wire logic        cmd_end,
   // Bus master side.
   input  wire logic        mst_req,
   output logic             mst_gnt,
   input  wire logic [23:0] mst_addr,
   input  wire logic        mst_we,
   input  wire logic [15:0] mst_wdata,
   output logic      [15:0] mst_rdata,
   output logic             mst_ack,
   // Chip side.
   input  wire logic        fdc_rd,
   input  wire logic        fdc_wr,
   input  wire logic [7:0]  fdc_dout,
   output logic      [7:0]  fdc_din,
   output logic             fdc_drq,
   output logic             fdc_intrq,
   // Observed results.
   output logic      [15:0] mem [0:15],
   output int               n_ack,
   output logic      [7:0]  last_wr
);
   logic [3:0] cnt_q;
   logic       done_q;
   logic       rd_q;
   logic [7:0] idx_q;
   logic [7:0] left_q;
   // A released line shows the inverse, so a late sample cannot pass.
   assign fdc_din   = fdc_rd ? 8'hA0 + idx_q : ~(8'hA0 + idx_q);
   // The request drops with the read strobe, before the count is updated.
   assign fdc_drq   = (left_q != 8'h00) && !fdc_rd && !rd_q;
   assign fdc_intrq = cmd_end;
   assign mst_rdata = mst_ack ? 16'h1234 : 16'hEDCB;

   always_ff @(posedge mclk)
   begin
      mst_gnt <= mst_req && !reset;
      mst_ack <= 1'b0;
      if (!mst_req)
      begin
         cnt_q  <= 4'h0;
         done_q <= 1'b0;
      end
      else if (mst_gnt && !done_q)
      begin
         if (cnt_q == ack_lat)
         begin
            mst_ack <= 1'b1;
            done_q  <= 1'b1;
         end
         else
            cnt_q <= cnt_q + 4'h1;
      end
      if (reset)
         n_ack <= 0;
      else if (mst_ack && mst_we)
      begin
         mem[mst_addr[4:1]] <= mst_wdata;
         n_ack              <= n_ack + 1;
      end
   end

   always_ff @(posedge mclk)
   begin
      rd_q <= fdc_rd;
      if (fdc_wr)
         last_wr <= fdc_dout;
      if (reset)
      begin
         idx_q  <= 8'h00;
         left_q <= 8'h00;
      end
      else if (give_go)
         left_q <= give_n;
      else if (rd_q && !fdc_rd)
      begin
         idx_q <= idx_q + 8'h01;
         if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
      end
   end
endmodule // fdp_far_model

// ===== dv/fdp_port_bench.sv
// Self-checking bench of the floppy DMA bus port with its far-side model.
// Assumes the port is built with a small FIFO to keep runs short.
`timescale 1ns/10ps
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module fdp_port_bench
   import fdp_pkg::*;
;
   localparam logic [10:0] BASE = 11'h2A5;
   logic        mclk, reset, clk_en, reg_wr, reg_rd, reg_super;
   logic        mst_req, mst_gnt, mst_we, mst_ack, irq, give_go, cmd_end;
   logic        fdc_rd, fdc_wr, fdc_drq, fdc_intrq, led_green, led_red;
   logic        drv_double_density, drv_mini, drv_precomp;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, mst_wdata, mst_rdata, v;
   logic [23:0] mst_addr;
   logic [3:0]  mst_req_line, drv_select;
   logic [5:0]  irq_line;
   logic [1:0]  fdc_reg;
   logic [7:0]  fdc_dout, fdc_din, last_wr, give_n;
   logic [15:0] mem [0:15];
   int          n_ack, n_mismatch, checked, cyc, i, lv;

   fdp_port #(.FIFO_BYTES(8)) dut_u (.mclk(mclk), .reset(reset),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_super(reg_super),
      .reg_rdata(reg_rdata), .jmp_io_base(BASE),
      .jmp_breq_level(2'h2), .mst_req(mst_req),
      .mst_req_line(mst_req_line), .mst_gnt(mst_gnt),
      .mst_addr(mst_addr), .mst_we(mst_we), .mst_wdata(mst_wdata),
      .mst_rdata(mst_rdata), .mst_ack(mst_ack), .irq(irq),
      .irq_line(irq_line), .fdc_reg(fdc_reg), .fdc_rd(fdc_rd),
      .fdc_wr(fdc_wr), .fdc_dout(fdc_dout), .fdc_din(fdc_din),
      .fdc_drq(fdc_drq), .fdc_intrq(fdc_intrq), .drv_select(drv_select),
      .drv_double_density(drv_double_density), .drv_mini(drv_mini),
      .drv_precomp(drv_precomp), .led_green(led_green),
      .led_red(led_red));

   fdp_far_model far_u (.mclk(mclk), .reset(reset), .ack_lat(4'h3),
      .give_go(give_go), .give_n(give_n), .cmd_end(cmd_end),
      .mst_req(mst_req), .mst_gnt(mst_gnt), .mst_addr(mst_addr),
      .mst_we(mst_we), .mst_wdata(mst_wdata), .mst_rdata(mst_rdata),
      .mst_ack(mst_ack), .fdc_rd(fdc_rd), .fdc_wr(fdc_wr),
      .fdc_dout(fdc_dout), .fdc_din(fdc_din), .fdc_drq(fdc_drq),
      .fdc_intrq(fdc_intrq), .mem(mem), .n_ack(n_ack),
      .last_wr(last_wr));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic wr_a(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd_a(input logic [15:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wr(input logic [3:0] ix, input logic [15:0] d);
      wr_a({BASE, ix, 1'b0}, d);
   endtask

   task automatic rd(input logic [3:0] ix, output logic [15:0] d);
      rd_a({BASE, ix, 1'b0}, d);
   endtask

   // Bounded waits keep a dead handshake from hanging the run.
   task automatic wait_irq(input int n);
      for (int k = 0; k < n && irq !== 1'b1; k++)
         @(posedge mclk);
      #1;
   endtask

   task automatic chip_idle();
      logic [15:0] s;
      for (int k = 0; k < 50; k++)
      begin
         rd(OFS_STAT, s);
         if (s[STAT_PIO] === 1'b0)
            break;
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         $display("ERROR at %0t: timeout", $time);
         end_of_test();
      end
   end

   initial
   begin
      {reg_wr, reg_rd, give_go, cmd_end, give_n} = '0;
      {reg_addr, reg_wdata} = '0;
      {clk_en, reg_super, reset} = 3'b111;
      {n_mismatch, checked, cyc} = '0;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(OFS_CTRL, v);
      `CHK(v, 16'h0000)
      `CHK(led_red, 1'b1)
      `CHK(drv_select, 4'h1)
      wr(OFS_CTRL, 16'h0080);
      `CHK({led_green, led_red}, 2'b10)
      $display("test reset_and_lamp done");
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_DRV, 16'({i[0] ^ i[1], i[1], i[0], i[1:0]}));
         `CHK(drv_select, 4'h1 << i)
         `CHK({drv_precomp, drv_mini}, {i[0] ^ i[1], i[1]})
         `CHK(drv_double_density, i[0])
      end
      $display("test drive_control done");
      wr_a({BASE + 11'h001, 5'h00}, 16'h0000);
      `CHK(led_green, 1'b1)
      rd_a({BASE ^ 11'h400, 5'h00}, v);
      `CHK(v, 16'h0000)
      reg_super <= 1'b0;
      rd(OFS_CTRL, v);
      `CHK(v, 16'h0000)
      wr(OFS_CTRL, 16'h0000);
      `CHK(led_green, 1'b1)
      reg_super <= 1'b1;
      wr(OFS_CTRL, 16'h00C0);
      reg_super <= 1'b0;
      rd(OFS_CTRL, v);
      `CHK(v, 16'h00C0)
      reg_super <= 1'b1;
      $display("test window_and_access done");
      wr(OFS_IEN, 16'h0001);
      for (lv = 1; lv <= 6; lv++)
      begin
         wr(OFS_CTRL, 16'(lv));
         cmd_end <= 1'b1;
         wait_irq(20);
         `CHK(irq_line, 6'h01 << (lv - 1))
         cmd_end <= 1'b0;
         wr(OFS_ICLR, 16'h0001);
         `CHK(irq, 1'b0)
      end
      wr(OFS_IEN, 16'h0000);
      cmd_end <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(OFS_ISTAT, v);
      `CHK({irq, v}, 17'h00001)
      cmd_end <= 1'b0;
      wr(OFS_ICLR, 16'h0001);
      $display("test interrupt done");
      wr(OFS_ADRL, 16'h0010);
      wr(OFS_ADRH, 16'h0000);
      wr(OFS_CNT, 16'h0003);
      wr(OFS_IEN, 16'h0002);
      wr(OFS_CTRL, 16'h001B);
      repeat (40) @(posedge mclk);
      `CHK(mst_req, 1'b0)
      give_n  <= 8'h06;
      give_go <= 1'b1;
      @(posedge mclk);
      give_go <= 1'b0;
      for (i = 0; i < 2000 && mst_req !== 1'b1; i++)
         @(posedge mclk);
      #1 `CHK(mst_req_line, 4'b0100)
      wait_irq(3000);
      `CHK(n_ack, 3)
      for (i = 0; i < 3; i++)
         `CHK(mem[8 + i], {8'hA0 + 8'(2 * i), 8'hA1 + 8'(2 * i)})
      rd(OFS_CNT, v);
      `CHK(v, 16'h0000)
      rd(OFS_ADRL, v);
      `CHK(v, 16'h0016)
      rd(OFS_ISTAT, v);
      `CHK({irq_line, v}, 22'h040002)
      wr(OFS_ICLR, 16'h0003);
      wr(OFS_CTRL, 16'h0000);
      $display("test dma_disk_to_memory done");
      rd(4'hF, v);
      chip_idle();
      rd(4'hF, v);
      `CHK(v[7:0], 8'hA6)
      chip_idle();
      rd(OFS_STAT, v);
      `CHK(v[12:4], 9'h000)
      wr(4'hE, 16'h005A);
      repeat (12) @(posedge mclk);
      `CHK({fdc_reg, last_wr}, {2'h2, 8'h5A})
      $display("test programmed_bytes done");
      wr(OFS_CNT, 16'h0001);
      wr(OFS_CTRL, 16'h000B);
      give_n  <= 8'h01;
      give_go <= 1'b1;
      wait_irq(3000);
      give_go <= 1'b0;
      repeat (30) @(posedge mclk);
      `CHK({irq, fdc_reg, last_wr}, {1'b1, 2'h3, 8'h34})
      `CHK(n_ack, 3)
      $display("test dma_memory_to_disk done");
      end_of_test();
   end
endmodule // fdp_port_bench
